/* rtl/adcrc_correct.sv */
module adcrc_correct
  import adcrc_pkg::*;
(
  // raw result and settings
  input  wire logic [23:0]       raw_i,
  input  adcrc_cal_type          cal_i,
  input  wire logic [2:0]        osr_code_i,
  input  wire logic              offset_en_i,
  input  wire logic              gain_en_i,
  // corrected value, wide
  output logic [WIDE_W-1:0]      value_o
);

  logic [23:0] off_masked;
  logic [24:0] sum;
  logic [25:0] mult;
  logic [50:0] prod;

  always_comb
  begin
    off_masked = cal_i.offset & adcrc_offset_mask(osr_code_i); // R17
    sum        = {raw_i[23], raw_i};
    if (offset_en_i)
    begin
      sum = sum + {off_masked[23], off_masked}; // R16
    end
    mult = GAIN_ONE + {{2{cal_i.gain[23]}}, cal_i.gain}; // R21
    prod = 51'($signed(sum) * $signed(mult)); // R24
    if (gain_en_i)
    begin
      value_o = prod[50:23]; // R14
    end
    else
    begin
      value_o = {{3{sum[24]}}, sum};
    end
  end

endmodule

/* rtl/adcrc_pkg.sv */
// Overview of operation
// R1: crystal oscillator runs only while external clock select is 0, four-wire mode only.
// R2: external clock select 1 buffers clock input; second crystal pin becomes mode input.
// R3: mode input low keeps four-wire interface; high selects two-wire interface.
// R4: host keeps master clock below 20 MHz and sample clock within limits.
// R5: one ready flag per channel in status word, readable any time, besides pin.
// R6: writes to the ready flags are ignored.
// R7: flags reset to 1 and go to 0 when that channel's result updates.
// R8: any status read returns all ready flags to 1.
// R9: linked mode updates all flags together with the most lagging channel's pulse; code updates only the flags of active (non-held) channels.
// R10: unlinked mode updates each flag with its own channel's result.
// R11: unlinked mode puts both channels' pulses on the active-low ready pin.
// R12: linked mode, the reset default, shows only the most lagging active channel's pulse.
// R13: linked mode latches all active channels' results together at lagging channel ready.
// R14: offset and gain correction under two enables: (raw + offset) times (1 + gain).
// R15: both corrections are bypassed in two-wire mode.
// R16: offset is two's complement, result LSB weight, added with no extra latency.
// R17: offset is masked to current resolution; ratio 32 adds only top 17 bits.
// R18: no offset addition for a channel in reset or shutdown.
// R19: no gain multiplication for a channel in reset or shutdown.
// R20: clearing an enable keeps stored offset and gain values, just ignored.
// R21: gain is signed 24-bit, LSB 2^-23, plus one, multiplier 0 to under 2.
// R22: gain enable adds 24 modulator periods to results and pulses, from next pulse.
// R23: out-of-range results saturate to 7FFF/8000 or 7FFFFF/800000.
// R24: gain product kept at full precision, truncated, then saturated.
package adcrc_pkg;

  localparam int          CH_NUM           = 2;
  localparam int          DATA_W           = 24;
  localparam int          WIDE_W           = 28;
  localparam logic [4:0]  GAIN_DELAY_TICKS = 5'h18;
  localparam logic [25:0] GAIN_ONE         = 26'h080_0000;
  localparam logic [1:0]  FLAGS_RESET      = 2'h3;
  localparam logic        LINK_RESET       = 1'b1;
  localparam logic [23:0] MAX_24           = 24'h7f_ffff;
  localparam logic [23:0] MIN_24           = 24'h80_0000;
  localparam logic [15:0] MAX_16           = 16'h7fff;
  localparam logic [15:0] MIN_16           = 16'h8000;

  typedef struct packed
  {
    logic [23:0] offset;
    logic [23:0] gain;
  } adcrc_cal_type;

  typedef struct packed
  {
    logic       link;
    logic [1:0] flags;
  } adcrc_status_type;

  typedef enum logic {DLY_IDLE, DLY_WAIT} adcrc_dly_type;

  // significant result bits per decimation code (ratio 32 .. 4096)
  function automatic logic [23:0] adcrc_offset_mask(input logic [2:0] code);
    logic [23:0] m;
    m = 24'hff_ffff;
    unique case (code)
      3'h0: m = 24'hff_ff80;
      3'h1: m = 24'hff_fff0;
      3'h2: m = 24'hff_fffe;
      default: m = 24'hff_ffff;
    endcase
    return m;
  endfunction

endpackage

/* rtl/adcrc_ready_cal.sv */
module adcrc_ready_cal
  import adcrc_pkg::*;
(
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    reset_i,
  // configuration bits
  input  wire logic                    external_clock_select_i,
  input  wire logic                    crystal_pin_out_i,
  input  wire logic                    offset_correction_enable_i,
  input  wire logic                    gain_correction_enable_i,
  input  wire logic [2:0]              decimation_ratio_field_i,
  input  wire logic                    resolution_24_i,
  input  adcrc_cal_type [CH_NUM-1:0]   channel_cal_i,
  // converter side
  input  wire logic                    modulator_clock_tick_i,
  input  wire logic [CH_NUM-1:0]       channel_hold_i,
  input  wire logic [CH_NUM-1:0]       raw_valid_i,
  input  wire logic [CH_NUM-1:0][23:0] raw_data_i,
  // status word access
  input  wire logic                    status_read_i,
  input  wire logic                    status_write_i,
  input  adcrc_status_type             status_wdata_i,
  output adcrc_status_type             status_rdata_o,
  // clock and mode outputs
  output logic                         oscillator_enable_o,
  output logic                         clock_buffer_select_o,
  output logic                         two_wire_mode_o,
  // results and ready
  output logic [CH_NUM-1:0][23:0]      channel_result_o,
  output logic                         ready_pulse_pin_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                      mode_s1_r;
  logic                      mode_s2_r;
  logic                      two_wire;
  logic                      link_r;
  logic [CH_NUM-1:0]         flags_r;
  logic [CH_NUM-1:0]         pend_r;
  logic [CH_NUM-1:0]         pend_nxt;
  logic [CH_NUM-1:0]         active;
  logic [CH_NUM-1:0]         fire;
  logic [CH_NUM-1:0]         out_mask;
  logic                      gain_now;
  logic                      use_gain;
  logic                      ready_n_r;
  adcrc_dly_type             dly_state_r;
  logic [4:0]                dly_cnt_r;
  logic [CH_NUM-1:0]         dly_mask_r;
  logic                      dly_done;
  logic [CH_NUM-1:0][23:0]   raw_hold_r;
  logic [CH_NUM-1:0][23:0]   raw_cur;
  logic [CH_NUM-1:0][23:0]   sat_val;
  logic [CH_NUM-1:0][23:0]   result_r;

  ////////////////////////////////////////////////////////////////////////////
  // clock source and interface mode

  // mode pin is asynchronous to this clock
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end
    else
    begin
      mode_s1_r <= crystal_pin_out_i;
      mode_s2_r <= mode_s1_r;
    end
  end

  // mode pin only counts when the crystal pin is freed
  assign two_wire              = external_clock_select_i & mode_s2_r; // R2 R3
  assign oscillator_enable_o   = ~external_clock_select_i; // R1
  assign clock_buffer_select_o = external_clock_select_i; // R2
  assign two_wire_mode_o       = two_wire;

  ////////////////////////////////////////////////////////////////////////////
  // status word: link bit and ready flags

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      link_r <= LINK_RESET; // R12
    end
    else if (status_write_i)
    begin
      link_r <= status_wdata_i.link;
    end
  end

  // flags ignore status writes; update wins over a read in the same cycle
  generate
    for (genvar n = 0; n < CH_NUM; n++)
    begin : g_flag
      always_ff @(posedge clock_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          flags_r[n] <= FLAGS_RESET[n]; // R7
        end
        else if (out_mask[n])
        begin
          flags_r[n] <= 1'b0; // R7
        end
        else if (status_read_i)
        begin
          flags_r[n] <= 1'b1; // R8
        end
      end
    end
  endgenerate

  assign status_rdata_o.link  = link_r;
  assign status_rdata_o.flags = flags_r; // R5 R6

  ////////////////////////////////////////////////////////////////////////////
  // result events, linked or independent

  assign active   = ~channel_hold_i;
  assign pend_nxt = pend_r | raw_valid_i;

  always_comb
  begin
    fire = '0;
    if (link_r)
    begin
      // the channel that completes the active set is the lagging one
      if ((active != '0) && ((pend_nxt & active) == active))
      begin
        fire = active; // R9 R13
      end
    end
    else
    begin
      fire = raw_valid_i; // R10
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pend_r <= '0;
    end
    else if (!link_r || (fire != '0))
    begin
      pend_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt & active;
    end
  end

  generate
    for (genvar n = 0; n < CH_NUM; n++)
    begin : g_raw
      always_ff @(posedge clock_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          raw_hold_r[n] <= '0;
        end
        else if (raw_valid_i[n])
        begin
          raw_hold_r[n] <= raw_data_i[n];
        end
      end
      assign raw_cur[n] = raw_valid_i[n] ? raw_data_i[n] : raw_hold_r[n];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // gain pipeline delay

  // a new event cannot arrive inside the wait at the shortest ratio
  assign gain_now = gain_correction_enable_i & ~two_wire; // R15
  assign dly_done = (dly_state_r == DLY_WAIT) && modulator_clock_tick_i
                    && (dly_cnt_r == GAIN_DELAY_TICKS - 5'h01);
  assign use_gain = (dly_state_r == DLY_WAIT); // R22

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      dly_state_r <= DLY_IDLE;
      dly_cnt_r   <= '0;
      dly_mask_r  <= '0;
    end
    else
    begin
      unique case (dly_state_r)
        DLY_IDLE:
        begin
          if ((fire != '0) && gain_now)
          begin
            dly_state_r <= DLY_WAIT; // R22
            dly_cnt_r   <= '0;
            dly_mask_r  <= fire;
          end
        end
        DLY_WAIT:
        begin
          if (dly_done)
          begin
            dly_state_r <= DLY_IDLE;
          end
          else if (modulator_clock_tick_i)
          begin
            dly_cnt_r <= dly_cnt_r + 5'h01; // R22
          end
        end
      endcase
    end
  end

  always_comb
  begin
    out_mask = '0;
    if ((dly_state_r == DLY_IDLE) && !gain_now)
    begin
      out_mask = fire;
    end
    else if (dly_done)
    begin
      out_mask = dly_mask_r; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // correction, saturation and output latch

  generate
    for (genvar n = 0; n < CH_NUM; n++)
    begin : g_chan
      logic [WIDE_W-1:0] value;
      logic              bypass;

      // held channels and two-wire mode skip both corrections
      assign bypass = channel_hold_i[n] | two_wire; // R15 R18 R19

      adcrc_correct u_correct
      (
        .raw_i       (raw_cur[n]),
        .cal_i       (channel_cal_i[n]), // R20
        .osr_code_i  (decimation_ratio_field_i),
        .offset_en_i (offset_correction_enable_i & ~bypass), // R14 R18
        .gain_en_i   (use_gain & ~bypass), // R14 R19
        .value_o     (value)
      );

      adcrc_saturate u_saturate
      (
        .value_i (value),
        .res24_i (resolution_24_i),
        .sat_o   (sat_val[n])
      );

      always_ff @(posedge clock_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          result_r[n] <= '0;
        end
        else if (out_mask[n])
        begin
          result_r[n] <= sat_val[n]; // R13
        end
      end
    end
  endgenerate

  assign channel_result_o = result_r;

  // one low cycle per ready event
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ready_n_r <= 1'b1;
    end
    else
    begin
      ready_n_r <= ~|out_mask; // R11 R12
    end
  end

  assign ready_pulse_pin_n_o = ready_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  flag_update_a: assert property ( // R7
    out_mask[0] |=> !flags_r[0]
  ) else $error("flag 0 not cleared on update");

  flag_read_a: assert property ( // R8
    status_read_i && (out_mask == '0) |=> (flags_r == 2'h3)
  ) else $error("status read did not restore flags");

  flag_write_a: assert property ( // R6
    status_write_i && !status_read_i && (out_mask == '0) |=> $stable(flags_r)
  ) else $error("status write changed flags");

  pin_pulse_a: assert property ( // R11
    (out_mask != '0) |=> !ready_pulse_pin_n_o ##1 (ready_pulse_pin_n_o || $past(out_mask != '0))
  ) else $error("ready pin pulse wrong");

  link_group_a: assert property ( // R9
    link_r && (dly_state_r == DLY_IDLE) && (fire != '0) |-> (fire == active)
  ) else $error("linked event not for all active channels");

  unlinked_flag_a: assert property ( // R10
    !link_r && !gain_now && (dly_state_r == DLY_IDLE) && raw_valid_i[1]
      |=> !flags_r[1] && !ready_pulse_pin_n_o
  ) else $error("unlinked channel 1 not flagged");

  gain_delay_a: assert property ( // R22
    (dly_state_r == DLY_WAIT) && !dly_done |-> (out_mask == '0)
  ) else $error("event released before gain delay");

  gain_start_a: assert property ( // R22
    (dly_state_r == DLY_IDLE) && (fire != '0) && gain_now
      |=> (dly_state_r == DLY_WAIT) && (dly_cnt_r == 5'h00) && !ready_pulse_pin_n_o == 1'b0
  ) else $error("gain delay did not start");

  osc_mode_a: assert property ( // R1
    oscillator_enable_o |-> !two_wire_mode_o && !clock_buffer_select_o
  ) else $error("oscillator on outside four-wire mode");

  two_wire_a: assert property ( // R15
    two_wire_mode_o && (dly_state_r == DLY_IDLE) |=> (dly_state_r == DLY_IDLE)
  ) else $error("gain delay started in two-wire mode");

endmodule

/* rtl/adcrc_saturate.sv */
module adcrc_saturate
  import adcrc_pkg::*;
(
  // wide value and width mode
  input  wire logic [WIDE_W-1:0] value_i,
  input  wire logic              res24_i,
  // clamped result
  output logic [23:0]            sat_o
);

  always_comb
  begin
    if (res24_i)
    begin
      if ($signed(value_i) > $signed({4'h0, MAX_24}))
        sat_o = MAX_24; // R23
      else if ($signed(value_i) < $signed({4'hf, MIN_24}))
        sat_o = MIN_24; // R23
      else
        sat_o = value_i[23:0];
    end
    else
    begin
      if ($signed(value_i) > $signed({12'h000, MAX_16}))
        sat_o = {8'h00, MAX_16}; // R23
      else if ($signed(value_i) < $signed({12'hfff, MIN_16}))
        sat_o = {8'h00, MIN_16}; // R23
      else
        sat_o = {8'h00, value_i[15:0]};
    end
  end

endmodule

/* test/adcrc_host.sv */
module adcrc_host
  import adcrc_pkg::*;
(
  // clock
  input  wire logic        clock_i,
  // status word access
  output logic             status_read_o,
  output logic             status_write_o,
  output adcrc_status_type status_wdata_o,
  input  adcrc_status_type status_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    status_read_o  = 1'b0;
    status_write_o = 1'b0;
    status_wdata_o = '0;
  end

  // word seen at the taking edge, clear lands after it
  task automatic read_status(output adcrc_status_type st);
    @(negedge clock_i);
    status_read_o = 1'b1;
    st = status_rdata_i;
    @(negedge clock_i);
    status_read_o = 1'b0;
  endtask

  // released data shows the inverse, not the old value
  task automatic write_status(input adcrc_status_type st);
    @(negedge clock_i);
    status_write_o = 1'b1;
    status_wdata_o = st;
    @(negedge clock_i);
    status_write_o = 1'b0;
    status_wdata_o = ~st;
  endtask
endmodule

/* test/tb_top.sv */
module tb_top
  import adcrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clock_i = 1'b0;
  logic                  reset_i, ext_sel, mode_pin, off_en, gain_en, res24, tick;
  logic [2:0]            ratio;
  logic [1:0]            hold, rv;
  logic [1:0][23:0]      raw, res;
  adcrc_cal_type [1:0]   cal;
  adcrc_status_type      rd, wd, st;
  logic                  sread, swrite, osc_en, buf_sel, two_wire, pin_n;
  int                    n_errors, comparisons, cnt;

  adcrc_ready_cal dut (.clock_i(clock_i), .reset_i(reset_i),
    .external_clock_select_i(ext_sel), .crystal_pin_out_i(mode_pin),
    .offset_correction_enable_i(off_en), .gain_correction_enable_i(gain_en),
    .decimation_ratio_field_i(ratio), .resolution_24_i(res24), .channel_cal_i(cal),
    .modulator_clock_tick_i(tick), .channel_hold_i(hold), .raw_valid_i(rv),
    .raw_data_i(raw), .status_read_i(sread), .status_write_i(swrite),
    .status_wdata_i(wd), .status_rdata_o(rd), .oscillator_enable_o(osc_en),
    .clock_buffer_select_o(buf_sel), .two_wire_mode_o(two_wire),
    .channel_result_o(res), .ready_pulse_pin_n_o(pin_n));

  adcrc_host h (.clock_i(clock_i), .status_read_o(sread), .status_write_o(swrite),
    .status_wdata_o(wd), .status_rdata_i(rd));

  initial
  begin
    forever #2.5 clock_i = ~clock_i;
  end

  // modulator tick every second cycle, well inside the rate limits
  always @(negedge clock_i) tick <= ~tick;

  task automatic wrap_up();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one event, returns in the cycle after the taking edge
  task automatic fire(input logic [1:0] m, input logic [23:0] d0, input logic [23:0] d1);
    @(negedge clock_i);
    rv = m;
    raw[0] = d0;
    raw[1] = d1;
    @(negedge clock_i);
    rv = 2'b00;
  endtask

  // gain path: wait for the delayed pulse, then compare channel 0
  task automatic gfire(input logic [23:0] d0, input logic [23:0] exp);
    @(negedge clock_i);
    rv = 2'b01;
    raw[0] = d0;
    @(negedge clock_i);
    rv = 2'b00;
    cnt = 1;
    while (pin_n !== 1'b0 && cnt < 200)
    begin
      @(negedge clock_i);
      cnt++;
    end
    chk(24'(cnt >= 46 && cnt <= 51), 24'h00_0001);
    chk(res[0], exp);
  endtask

  task automatic rdst(input logic [1:0] exp);
    h.read_status(st);
    chk(24'(st.flags), 24'(exp));
  endtask

  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    {ext_sel, mode_pin, off_en, gain_en, tick} = '0;
    {ratio, hold, rv, raw, cal} = '0;
    res24 = 1'b1;
    reset_i = 1'b1;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(negedge clock_i);
    reset_i = 1'b0;
    chk(24'(rd.flags), 24'h00_0003);
    chk(24'(rd.link), 24'h00_0001);
    chk(24'(pin_n), 24'h00_0001);
    chk(24'({osc_en, buf_sel, two_wire}), 24'h00_0004);
    ext_sel = 1'b1;
    mode_pin = 1'b1;
    repeat (4) @(negedge clock_i);
    chk(24'({osc_en, buf_sel, two_wire}), 24'h00_0003);
    off_en = 1'b1;
    ratio = 3'h7;
    cal[0].offset = 24'h00_0100;
    cal[0].gain = 24'h40_0000;
    gain_en = 1'b1;
    fire(2'b11, 24'h00_0010, 24'h00_0020);
    chk(res[0], 24'h00_0010);
    chk(24'(pin_n), 24'h00_0000);
    gain_en = 1'b0;
    mode_pin = 1'b0;
    repeat (4) @(negedge clock_i);
    chk(24'(two_wire), 24'h00_0000);
    rdst(2'b00);
    rdst(2'b11);
    h.write_status('{link: 1'b0, flags: 2'b00});
    h.read_status(st);
    chk(24'({st.link, st.flags}), 24'h00_0003);
    ratio = 3'h0;
    cal[0].offset = 24'h00_0085;
    fire(2'b01, 24'h00_0100, 24'h00_0020);
    chk(res[0], 24'h00_0180);
    chk(24'({pin_n, rd.flags}), 24'h00_0002);
    hold = 2'b10;
    cal[1].offset = 24'h00_0100;
    fire(2'b10, 24'h00_0100, 24'h00_0055);
    chk(res[1], 24'h00_0055);
    chk(24'(pin_n), 24'h00_0000);
    hold = 2'b00;
    h.write_status('{link: 1'b1, flags: 2'b00});
    rdst(2'b00);
    fire(2'b01, 24'h00_0200, 24'h00_0300);
    chk(24'({pin_n, rd.flags}), 24'h00_0007);
    chk(res[0], 24'h00_0180);
    fire(2'b10, 24'h00_0200, 24'h00_0300);
    chk(24'({pin_n, rd.flags}), 24'h00_0000);
    chk(res[0], 24'h00_0280);
    chk(res[1], 24'h00_0400);
    h.write_status('{link: 1'b0, flags: 2'b11});
    ratio = 3'h7;
    cal[0].offset = 24'h00_0001;
    fire(2'b01, 24'h7f_ffff, 24'h00_0000);
    chk(res[0], 24'h7f_ffff);
    res24 = 1'b0;
    fire(2'b01, 24'h00_7fff, 24'h00_0000);
    chk(res[0], 24'h00_7fff);
    cal[0].offset = 24'hff_ffff;
    fire(2'b01, 24'hff_8000, 24'h00_0000);
    chk(res[0], 24'h00_8000);
    res24 = 1'b1;
    off_en = 1'b0;
    fire(2'b01, 24'h00_0010, 24'h00_0000);
    chk(res[0], 24'h00_0010);
    off_en = 1'b1;
    fire(2'b01, 24'h00_0010, 24'h00_0000);
    chk(res[0], 24'h00_000f);
    ratio = 3'h1;
    fire(2'b01, 24'h00_0010, 24'h00_0000);
    chk(res[0], 24'h00_0000);
    ratio = 3'h2;
    fire(2'b01, 24'h00_0010, 24'h00_0000);
    chk(res[0], 24'h00_000e);
    off_en = 1'b0;
    gain_en = 1'b1;
    cal[0].gain = 24'h40_0000;
    gfire(24'h00_0100, 24'h00_0180);
    cal[0].gain = 24'hc0_0000;
    gfire(24'hff_fffd, 24'hff_fffe);
    hold = 2'b01;
    gfire(24'h00_0100, 24'h00_0100);
    wrap_up();
  end
endmodule
